// file: rtl/charge_time_unit.sv
// Purpose: Control logic of the charge-time measurement unit with an AXI4-Lite slave.
// Assumes: All inputs synchronous to aclk; power-mode requests are levels.
// Notes:   Registers are bytes in the low lane of aligned words.
// What this block does
// [R1] Time generation enable selects pulse-delay mode output.
// [R2] Edge 1 starts charge; comparator trip ends pulse.
// [R3] Sleep entry always disables the current source.
// [R4] Idle disables source only when stop bit set.
// [R5] Reset clears every control register to zero.
// [R6] Reset abandons any measurement in progress.
// [R7] Software discharges residue by pulsing ground bit.
// [R8] Ground bit high grounds current source output.
// [R9] Edge enable clear blocks all edge events.
// [R10] Order enable: edge 2 waits for edge 1.
// [R11] Converter trigger driven only when trigger enabled.
// [R12] Polarity bit picks rising or falling edge.
// [R13] Two-bit select picks one of four sources.
// [R14] Status bits set by edges, writable by software.
// [R15] Six-bit trim is signed current adjustment.
// [R16] Range field selects x100, x10, base, off.
// [R17] Unimplemented bits ignore writes, read zero.
// [R18] Source on: enabled, range, edge1 set, edge2 clear.
// [R19] Qualified selected edge sets matching status bit.
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "charge_time_unit_defs.svh"

module charge_time_unit
  import charge_time_unit_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [3:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [3:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire edge_sources_t edge_sources,
  input  wire logic          comparator_trip,
  input  wire logic          sleep_mode,
  input  wire logic          idle_mode,
  output analog_ctl_t        analog_ctl,
  output logic               converter_trigger,
  output logic               pulse_out_pin
);

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  ctl_high_t    high_ff;
  ctl_low_t     low_ff;
  cur_ctl_t     cur_ff;
  pulse_state_t pulse_state_ff;
  pulse_state_t nxt_pulse_state;
  logic         edge1_seen_ff;

  // --------------------------------------------------------------------------
  // Write channel: address and data taken in either order
  // --------------------------------------------------------------------------
  logic [3:0]  awaddr_ff;
  logic        aw_held_ff;
  logic [31:0] wdata_ff;
  logic        wstrb0_ff;
  logic        w_held_ff;

  wire logic aw_take  = s_axi_awvalid && s_axi_awready;
  wire logic w_take   = s_axi_wvalid && s_axi_wready;
  wire logic wr_fire  = aw_held_ff && w_held_ff && !s_axi_bvalid;
  wire logic wr_lane0 = wr_fire && wstrb0_ff;
  wire logic wr_high  = wr_lane0 && (awaddr_ff == `CTU_OFF_CONTROL_HIGH);
  wire logic wr_low   = wr_lane0 && (awaddr_ff == `CTU_OFF_CONTROL_LOW);
  wire logic wr_cur   = wr_lane0 && (awaddr_ff == `CTU_OFF_CURRENT_CONTROL);
  wire logic wr_map   = (awaddr_ff == `CTU_OFF_CONTROL_HIGH) ||
                        (awaddr_ff == `CTU_OFF_CONTROL_LOW) ||
                        (awaddr_ff == `CTU_OFF_CURRENT_CONTROL) ||
                        (awaddr_ff == `CTU_OFF_PIN_STATUS);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_held_ff    <= 1'b0;
      w_held_ff     <= 1'b0;
      awaddr_ff     <= 4'h0;
      wdata_ff      <= 32'h00000000;
      wstrb0_ff     <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CTU_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held_ff && !aw_take && !s_axi_bvalid;
      s_axi_wready  <= !w_held_ff && !w_take && !s_axi_bvalid;
      if (aw_take)
      begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= {s_axi_awaddr[3:2], 2'h0};
      end
      if (w_take)
      begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb0_ff <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `CTU_RESP_OKAY : `CTU_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------------
  wire logic       ar_take  = s_axi_arvalid && s_axi_arready;
  wire logic [3:0] rd_addr  = {s_axi_araddr[3:2], 2'h0};
  wire logic [7:0] rd_high  = high_ff & `CTU_HIGH_WRITE_MASK; // [R17]
  wire logic [7:0] rd_stat  = {4'h0, edge_sources};
  wire logic       rd_map   = (rd_addr == `CTU_OFF_CONTROL_HIGH) ||
                              (rd_addr == `CTU_OFF_CONTROL_LOW) ||
                              (rd_addr == `CTU_OFF_CURRENT_CONTROL) ||
                              (rd_addr == `CTU_OFF_PIN_STATUS);
  wire logic [7:0] rd_byte  = (rd_addr == `CTU_OFF_CONTROL_HIGH)    ? rd_high :
                              (rd_addr == `CTU_OFF_CONTROL_LOW)     ? low_ff :
                              (rd_addr == `CTU_OFF_CURRENT_CONTROL) ? cur_ff :
                              (rd_addr == `CTU_OFF_PIN_STATUS)      ? rd_stat :
                                                                      8'h00;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `CTU_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= rd_map ? `CTU_RESP_OKAY : `CTU_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Edge detection and qualification
  // --------------------------------------------------------------------------
  logic edge1_hit;
  logic edge2_hit;

  edge_detect u_edge1 (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .sources    (edge_sources),
    .source_sel (low_ff.edge1_source_sel),
    .rising     (low_ff.edge1_polarity),
    .hit        (edge1_hit)
  );

  edge_detect u_edge2 (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .sources    (edge_sources),
    .source_sel (low_ff.edge2_source_sel),
    .rising     (low_ff.edge2_polarity),
    .hit        (edge2_hit)
  );

  wire logic edge1_ok = edge1_hit && high_ff.edges_unblock; // [R9]
  wire logic edge2_ok = edge2_hit && high_ff.edges_unblock &&
                        (!high_ff.edge_order_enable || edge1_seen_ff ||
                         low_ff.edge1_status); // [R10]

  wire ctl_low_t wr_low_val = wdata_ff[7:0];
  // Hardware set wins over a software clear in the same cycle.
  wire logic nxt_edge1_status = edge1_ok ||
                                (wr_low ? wr_low_val.edge1_status : low_ff.edge1_status); // [R19]
  wire logic nxt_edge2_status = edge2_ok ||
                                (wr_low ? wr_low_val.edge2_status : low_ff.edge2_status); // [R14]

  // --------------------------------------------------------------------------
  // Register update
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      high_ff       <= `CTU_RESET_BYTE; // [R5]
      low_ff        <= `CTU_RESET_BYTE;
      cur_ff        <= `CTU_RESET_BYTE;
      edge1_seen_ff <= 1'b0; // [R6]
    end
    else
    begin
      if (wr_high)
      begin
        high_ff <= wdata_ff[7:0] & `CTU_HIGH_WRITE_MASK; // [R17]
      end
      if (wr_cur)
      begin
        cur_ff <= wdata_ff[7:0];
      end
      low_ff <= {(wr_low ? wr_low_val[7:2] : low_ff[7:2]),
                 nxt_edge2_status, nxt_edge1_status};
      if (!high_ff.edge_order_enable || (wr_low && !wr_low_val.edge1_status))
      begin
        edge1_seen_ff <= 1'b0;
      end
      else if (edge1_ok)
      begin
        edge1_seen_ff <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pulse-delay sequencer
  // --------------------------------------------------------------------------
  wire logic pulse_mode = high_ff.unit_enable && high_ff.time_gen_enable; // [R1]

  always_comb
  begin
    nxt_pulse_state = pulse_state_ff;
    unique case (pulse_state_ff)
      PD_IDLE:
      begin
        if (pulse_mode && low_ff.edge1_status)
        begin
          nxt_pulse_state = PD_CHARGING; // [R2]
        end
      end
      PD_CHARGING:
      begin
        if (!pulse_mode || !low_ff.edge1_status)
        begin
          nxt_pulse_state = PD_IDLE;
        end
        else if (comparator_trip)
        begin
          nxt_pulse_state = PD_DONE; // [R2]
        end
      end
      PD_DONE:
      begin
        if (!pulse_mode || !low_ff.edge1_status)
        begin
          nxt_pulse_state = PD_IDLE;
        end
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Analog and output drive
  // --------------------------------------------------------------------------
  wire logic power_off  = sleep_mode || (idle_mode && high_ff.stop_in_idle); // [R3] [R4]
  wire logic charge_on  = high_ff.unit_enable &&
                          (cur_ff.current_range != `CTU_RANGE_OFF) &&
                          low_ff.edge1_status && !low_ff.edge2_status; // [R16]
  wire logic pulse_stop = pulse_mode && (pulse_state_ff == PD_DONE);
  wire analog_ctl_t nxt_analog = '{
    source_on:       charge_on && !power_off && !pulse_stop, // [R18]
    source_grounded: high_ff.source_ground, // [R8]
    range:           cur_ff.current_range,
    trim:            cur_ff.current_trim // [R15]
  };

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pulse_state_ff    <= PD_IDLE; // [R6]
      analog_ctl        <= '0;
      converter_trigger <= 1'b0;
      pulse_out_pin     <= 1'b0;
    end
    else
    begin
      pulse_state_ff    <= nxt_pulse_state;
      analog_ctl        <= nxt_analog;
      converter_trigger <= high_ff.unit_enable && high_ff.converter_trigger_enable &&
                           edge2_ok; // [R11]
      pulse_out_pin     <= pulse_mode && (nxt_pulse_state == PD_CHARGING); // [R1]
    end
  end

endmodule : charge_time_unit

// file: pkg/charge_time_unit_defs.svh
// Purpose: Offsets, reset values, masks, select and range codes and bus responses of the charge-time unit.
// Assumes: Included by its bare name from design and checker files.
// Notes:   Definitions only.
`ifndef CHARGE_TIME_UNIT_DEFS_SVH
`define CHARGE_TIME_UNIT_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define CTU_OFF_CONTROL_HIGH    4'h0
`define CTU_OFF_CONTROL_LOW     4'h4
`define CTU_OFF_CURRENT_CONTROL 4'h8
`define CTU_OFF_PIN_STATUS      4'hC

// ----------------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------------
`define CTU_RESET_BYTE          8'h00
`define CTU_HIGH_WRITE_MASK     8'hBF

// ----------------------------------------------------------------------------
// Edge source select codes
// ----------------------------------------------------------------------------
`define CTU_SEL_PIN_A           2'h3
`define CTU_SEL_PIN_B           2'h2
`define CTU_SEL_COMPARE_A       2'h1
`define CTU_SEL_COMPARE_B       2'h0

// ----------------------------------------------------------------------------
// Current range codes
// ----------------------------------------------------------------------------
`define CTU_RANGE_X100          2'h3
`define CTU_RANGE_X10           2'h2
`define CTU_RANGE_BASE          2'h1
`define CTU_RANGE_OFF           2'h0

// ----------------------------------------------------------------------------
// Bus response codes
// ----------------------------------------------------------------------------
`define CTU_RESP_OKAY           2'h0
`define CTU_RESP_SLVERR         2'h2

`endif

// file: pkg/charge_time_unit_pkg.sv
// Purpose: Types shared by the charge-time unit design files.
// Assumes: Field layouts follow the control register bit order, bit 7 first.
// Notes:   Constants live in the defs header.
package charge_time_unit_pkg;

  // --------------------------------------------------------------------------
  // Register layouts
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic unit_enable;
    logic unused_6;
    logic stop_in_idle;
    logic time_gen_enable;
    logic edges_unblock;
    logic edge_order_enable;
    logic source_ground;
    logic converter_trigger_enable;
  } ctl_high_t;

  typedef struct packed {
    logic       edge2_polarity;
    logic [1:0] edge2_source_sel;
    logic       edge1_polarity;
    logic [1:0] edge1_source_sel;
    logic       edge2_status;
    logic       edge1_status;
  } ctl_low_t;

  typedef struct packed {
    logic [5:0] current_trim;
    logic [1:0] current_range;
  } cur_ctl_t;

  // --------------------------------------------------------------------------
  // Analog-facing outputs
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       source_on;
    logic       source_grounded;
    logic [1:0] range;
    logic [5:0] trim;
  } analog_ctl_t;

  // --------------------------------------------------------------------------
  // Edge sources and pulse-delay sequencer states
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic edge_pin_a;
    logic edge_pin_b;
    logic compare_unit_a;
    logic compare_unit_b;
  } edge_sources_t;

  typedef enum logic [1:0] {
    PD_IDLE,
    PD_CHARGING,
    PD_DONE
  } pulse_state_t;

endpackage : charge_time_unit_pkg

// file: rtl/edge_detect.sv
// Purpose: Selects one edge source and flags a transition of the chosen polarity.
// Assumes: Sources are synchronous to aclk.
// Notes:   Instantiated once per edge channel.
`timescale 1ns/10ps
`include "charge_time_unit_defs.svh"

module edge_detect
  import charge_time_unit_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire edge_sources_t sources,
  input  wire logic [1:0]    source_sel,
  input  wire logic          rising,
  output logic               hit
);

  // --------------------------------------------------------------------------
  // Source selection
  // --------------------------------------------------------------------------
  wire logic sel_pin_a = (source_sel == `CTU_SEL_PIN_A);
  wire logic sel_pin_b = (source_sel == `CTU_SEL_PIN_B);
  wire logic sel_cmp_a = (source_sel == `CTU_SEL_COMPARE_A);
  wire logic chosen    = sel_pin_a ? sources.edge_pin_a :
                         sel_pin_b ? sources.edge_pin_b :
                         sel_cmp_a ? sources.compare_unit_a :
                                     sources.compare_unit_b; // [R13]

  logic prev_ff;
  logic sel_prev_ff;
  logic [1:0] sel_hold_ff;

  // A change of the select field is not itself taken as an edge.
  wire logic sel_stable = (sel_hold_ff == source_sel) && sel_prev_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prev_ff     <= 1'b0;
      sel_prev_ff <= 1'b0;
      sel_hold_ff <= 2'h0;
    end
    else
    begin
      prev_ff     <= chosen;
      sel_prev_ff <= 1'b1;
      sel_hold_ff <= source_sel;
    end
  end

  assign hit = sel_stable && (rising ? (chosen && !prev_ff)
                                     : (!chosen && prev_ff)); // [R12]

endmodule : edge_detect

// file: tb/charge_time_unit_chk.sv
// Purpose: Port-level assertions for the charge-time unit.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound to every instance of the unit.
`timescale 1ns/10ps
`include "charge_time_unit_defs.svh"

module charge_time_unit_chk
  import charge_time_unit_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        comparator_trip,
  input wire logic        sleep_mode,
  input wire analog_ctl_t analog_ctl,
  input wire logic        converter_trigger,
  input wire logic        pulse_out_pin
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // --------
  // Assertions
  // --------
  AST_RESET_CLEAR: assert property ($rose(aresetn) |-> analog_ctl == '0
    && !pulse_out_pin && !converter_trigger) else $error("outputs not clear after reset");
  AST_SLEEP_OFF: assert property (sleep_mode |=> !analog_ctl.source_on)
    else $error("source on during sleep");
  AST_ON_NEEDS_RANGE: assert property (analog_ctl.source_on |->
    analog_ctl.range != `CTU_RANGE_OFF) else $error("source on with range off");
  AST_PULSE_END: assert property (pulse_out_pin && comparator_trip |->
    ##[1:2] !pulse_out_pin) else $error("pulse kept after comparator trip");
  AST_BRESP_OKAY: assert property (s_axi_bvalid |-> s_axi_bresp == `CTU_RESP_OKAY)
    else $error("write response not okay");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  AST_R_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RDATA_HIGH_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == '0)
    else $error("unused read bits not zero");
  COV_READ_STALL: cover property (s_axi_rvalid && !s_axi_rready);
  COV_PULSE_END: cover property ($fell(pulse_out_pin));
  COV_SLEEP_CUT: cover property (sleep_mode && analog_ctl.source_on);
endmodule : charge_time_unit_chk

bind charge_time_unit charge_time_unit_chk chk_inst (.*);

// file: tb/cap_model.sv
// Purpose: Capacitor and comparator beside the unit's current source.
// Assumes: One charge step per cycle while the source drives.
// Notes:   Charge survives a reset of the unit, as a real capacitor would.
`timescale 1ns/10ps

module cap_model
  import charge_time_unit_pkg::*;
#(
  parameter int TRIP = 20
)
(
  input  wire logic        aclk,
  input  wire analog_ctl_t analog_ctl,
  output logic             comparator_trip
);
  int charge_ff = 0;

  always_ff @(posedge aclk)
  begin
    if (analog_ctl.source_grounded === 1'h1)
      charge_ff <= 0;
    else if (analog_ctl.source_on === 1'h1 && charge_ff < TRIP)
      charge_ff <= charge_ff + 1;
  end

  assign comparator_trip = charge_ff >= TRIP;
endmodule : cap_model

// file: tb/charge_time_unit_test.sv
// Purpose: Self-checking bench for the charge-time unit.
// Assumes: The bench drives the edge sources; cap_model is the capacitor.
// Notes:   Register rows first, then hand-written cases.
`timescale 1ns/10ps

module charge_time_unit_test
  import charge_time_unit_pkg::*;
;
  logic          aclk = 1'h0;
  logic          aresetn = 1'h0;
  logic [3:0]    awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic          awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic          arvalid = 1'h0, rready = 1'h0, sleep = 1'h0, idle = 1'h0;
  logic [31:0]   wdata = 32'h0, rdata;
  logic          awready, wready, bvalid, arready, rvalid, trip, trig, pulse;
  logic [1:0]    bresp, rresp;
  edge_sources_t es = 4'h4;
  analog_ctl_t   actl;
  logic [7:0]    rd;
  int            mismatches = 0, checks = 0, cycles = 0, trig_count = 0, n;
  logic [19:0]   rows [8] = '{20'h0FFBF, 20'h00000, 20'h4A0A0, 20'h45C5C,
                              20'h8FFFF, 20'h88686, 20'h87D7D, 20'hCFF04};

  always #2.5 aclk = ~aclk;

  charge_time_unit charge_time_unit_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .edge_sources(es),
    .comparator_trip(trip), .sleep_mode(sleep), .idle_mode(idle),
    .analog_ctl(actl), .converter_trigger(trig), .pulse_out_pin(pulse));

  cap_model cap_model_inst (.aclk(aclk), .analog_ctl(actl), .comparator_trip(trip));

  // --------
  // Tasks
  // --------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic aw_on;
    logic w_on;
    aw_on = 1'h1;
    w_on = 1'h1;
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (aw_on || w_on)
    begin
      @(posedge aclk);
      if (awready === 1'h1)
        awvalid <= 1'h0;
      if (wready === 1'h1)
        wvalid <= 1'h0;
      aw_on = aw_on && awready !== 1'h1;
      w_on = w_on && wready !== 1'h1;
    end
    bready <= 1'h1;
    do @(posedge aclk); while (bvalid !== 1'h1);
    bready <= 1'h0;
  endtask : wr

  // The read answer is left waiting a cycle so the hold of read data is exercised.
  task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string name);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    rready <= 1'h1;
    do @(posedge aclk); while (rvalid !== 1'h1);
    rd = rdata[7:0];
    rready <= 1'h0;
    check(name, {22'h0, rresp, rd}, {24'h0, e});
  endtask : rchk

  always @(posedge aclk)
  begin
    cycles++;
    if (trig === 1'h1)
      trig_count++;
    if (cycles == 20000)
    begin
      mismatches++;
      complete_run();
    end
  end

  // --------
  // Sequence
  // --------
  initial
  begin
    tick(2);
    aresetn <= 1'h1;
    tick(1);
    foreach (rows[i])
    begin
      wr(rows[i][19:16], rows[i][15:8]);
      tick(2);
      rchk(rows[i][19:16], rows[i][7:0], "register");
      if (rows[i][19:16] == 4'h8)
        check("analog", {24'h0, actl.trim, actl.range}, {24'h0, rows[i][7:0]});
    end
    wr(4'h8, 8'h01);
    wr(4'h0, 8'h80);
    wr(4'h4, 8'h5C);
    es.edge_pin_a <= 1'h1;
    tick(4);
    rchk(4'h4, 8'h5C, "blocked");
    wr(4'h0, 8'h88);
    es.edge_pin_a <= 1'h0;
    tick(4);
    rchk(4'h4, 8'h5C, "falling ignored");
    es.edge_pin_a <= 1'h1;
    tick(4);
    rchk(4'h4, 8'h5D, "edge1 set");
    check("source on", 32'(actl.source_on), 1);
    es.edge_pin_b <= 1'h0;
    tick(4);
    rchk(4'h4, 8'h5F, "edge2 set");
    check("source off", 32'(actl.source_on), 0);
    es.edge_pin_b <= 1'h1;
    wr(4'h0, 8'h8D);
    wr(4'h4, 8'h5C);
    es.edge_pin_b <= 1'h0;
    tick(4);
    rchk(4'h4, 8'h5C, "edge2 first");
    check("no trigger", 32'(trig_count), 0);
    es.edge_pin_b <= 1'h1;
    tick(4);
    es.edge_pin_a <= 1'h0;
    tick(4);
    es.edge_pin_a <= 1'h1;
    tick(4);
    es.edge_pin_b <= 1'h0;
    tick(4);
    rchk(4'h4, 8'h5F, "ordered edges");
    check("trigger", 32'(trig_count), 1);
    for (int s = 0; s < 4; s++)
    begin
      es[s] <= 1'h0;
      tick(4);
      wr(4'h4, {4'h1, s[1:0], 2'h0});
      tick(2);
      es[s] <= 1'h1;
      tick(4);
      rchk(4'h4, {4'h1, s[1:0], 2'h1}, "source select");
    end
    wr(4'h0, 8'h88);
    wr(4'h4, 8'h01);
    tick(2);
    check("software start", 32'(actl.source_on), 1);
    sleep <= 1'h1;
    tick(3);
    check("sleep", 32'(actl.source_on), 0);
    sleep <= 1'h0;
    tick(3);
    idle <= 1'h1;
    tick(3);
    check("idle run", 32'(actl.source_on), 1);
    wr(4'h0, 8'hA8);
    tick(2);
    check("idle stop", 32'(actl.source_on), 0);
    idle <= 1'h0;
    wr(4'h0, 8'h8A);
    wr(4'h4, 8'h00);
    tick(2);
    check("grounded", 32'(actl.source_grounded), 1);
    check("discharged", 32'(trip), 0);
    wr(4'h0, 8'h98);
    tick(2);
    check("not grounded", 32'(actl.source_grounded), 0);
    wr(4'h4, 8'h01);
    tick(2);
    check("pulse start", 32'(pulse), 1);
    for (n = 0; n < 200 && pulse === 1'h1; n++)
      @(posedge aclk);
    check("pulse end", 32'(pulse), 0);
    check("pulse width", 32'(n >= 18 && n <= 24), 1);
    wr(4'h0, 8'h88);
    wr(4'h4, 8'h01);
    tick(2);
    aresetn <= 1'h0;
    tick(2);
    aresetn <= 1'h1;
    tick(3);
    check("reset abandon", 32'(actl.source_on), 0);
    for (int a = 0; a < 3; a++)
      rchk(4'(a * 4), 8'h00, "reset value");
    complete_run();
  end
endmodule : charge_time_unit_test
